/* design/dbs_decode.sv */
// local processor support command decoder with buffer counters
module dbs_decode
	import dbs_pkg::*;
#(
	parameter logic [159:0] CFG_WORDS = '0,
	parameter logic [159:0] SERIAL = '0,
	parameter logic [63:0] FW_REV = {8{8'h30}},
	parameter logic [319:0] MODEL = {40{8'h20}}
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// local processor bus
	input wire logic [7:0] lcp_addr,
	input wire logic [7:0] lcp_wdata,
	input wire logic lcp_wr,
	input wire logic lcp_rd,
	output logic [7:0] lcp_rdata,
	output logic lcp_hit,
	// buffer byte transfer strobes
	input wire logic host_byte_xfer,
	input wire logic disk_byte_xfer,
	// sector progress and error reports
	input wire logic sector_done,
	input wire logic ctrl_fault,
	input wire logic uncorr_err,
	input wire logic corr_err,
	// diagnostic reports
	input wire logic diag_done,
	input wire logic diag_proc_ok,
	input wire logic diag_buf_ok,
	input wire logic diag_path_ok,
	input wire logic diag_ctrl_ok,
	// parameter block access
	input wire logic [5:0] param_index,
	output logic [15:0] param_data,
	// mode and status outputs
	output logic [7:0] host_block_cnt,
	output logic [7:0] disk_block_cnt,
	output logic host_drq,
	output logic host_irq,
	output logic busy,
	output logic sleep_mode,
	output logic idle_mode,
	output logic ecc7_mode,
	output logic read_mode,
	output logic prefetch,
	output logic multi_mode,
	output logic cmd_active,
	output logic cmd_terminated,
	output logic corrected_seen,
	output logic [8:0] sectors_left,
	output logic [7:0] error_code
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] host_cnt;
		logic [7:0] disk_cnt;
		logic drq;
		logic irq;
		logic busy;
		logic sleep;
		logic idle;
		logic ecc7;
		logic rd_mode;
		logic prefetch;
		logic multi;
		logic term;
		logic corr;
		logic [8:0] left;
		dbs_ms_e ms;
		logic active;
		logic [7:0] err;
		logic [7:0] rdata;
		logic hit;
		logic [15:0] pdata;
	} dbs_state_s;

	dbs_state_s st;
	dbs_state_s next_st;

	logic [5:0] dec_addr;
	logic sel;
	logic wr_sel;
	logic rd_sel;
	logic [15:0] rom_word;

	// ---------------------------------------------------------------
	// parameter table
	// ---------------------------------------------------------------
	dbs_param_rom #(
		.CFG_WORDS(CFG_WORDS),
		.SERIAL(SERIAL),
		.FW_REV(FW_REV),
		.MODEL(MODEL)
	) u_rom (
		.word_index(param_index),
		.word_data(rom_word)
	);

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	// top two bits dropped, so every alias selects the same command
	assign dec_addr = lcp_addr[ADDR_DECODE_BITS-1:0];
	// only 20h-27h answer; task file, buffer regs and 30h-3Fh stay silent
	assign sel = (dec_addr[5:3] == ADDR_HOST_CNT[5:3]);
	// strobes come from the local processor only, no host path exists
	assign wr_sel = sel & lcp_wr;
	assign rd_sel = sel & lcp_rd & ~lcp_wr;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		// one-cycle pulses fall back unless retriggered
		next_st.irq = 1'b0;
		next_st.prefetch = 1'b0;
		next_st.hit = sel & (lcp_wr | lcp_rd);
		next_st.rdata = RST_RDATA;
		next_st.pdata = rom_word;

		// counters step per byte moved on their own side
		if (host_byte_xfer) begin
			next_st.host_cnt = st.host_cnt + 8'h01;
		end
		if (disk_byte_xfer) begin
			next_st.disk_cnt = st.disk_cnt + 8'h01;
		end
		// a finished sector retires the pending data request
		if (sector_done) begin
			next_st.drq = 1'b0;
		end

		// multi-sector sequencing
		unique case (st.ms)
			MS_IDLE: begin
			end
			MS_RUN: begin
				if (ctrl_fault | uncorr_err) begin
					// host must issue a new command to go on
					next_st.ms = MS_STOP;
					next_st.term = 1'b1;
				end else if (sector_done) begin
					// 9-bit count so a load of zero runs 256 sectors
					next_st.left = st.left - 9'h001;
					if (st.left == 9'h001 || !st.multi) begin
						next_st.ms = MS_IDLE;
					end
				end
				// corrected data only noted, transfer continues
				if (corr_err) begin
					next_st.corr = 1'b1;
				end
			end
			MS_STOP: begin
			end
		endcase

		// diagnostic result, worst failure reported first
		if (diag_done) begin
			if (!diag_proc_ok) begin
				next_st.err = DIAG_PROC_ERR;
			end else if (!diag_buf_ok) begin
				next_st.err = DIAG_BUF_ERR;
			end else if (!diag_path_ok) begin
				next_st.err = DIAG_PATH_ERR;
			end else if (!diag_ctrl_ok) begin
				next_st.err = DIAG_CTRL_ERR;
			end else begin
				next_st.err = DIAG_OK;
			end
		end

		// local writes, acted on in the selecting cycle only
		if (wr_sel) begin
			unique case (dec_addr)
				ADDR_HOST_CNT: begin
					next_st.host_cnt = lcp_wdata;
				end
				ADDR_DISK_CNT: begin
					next_st.disk_cnt = lcp_wdata;
				end
				ADDR_CLR_SLEEP: begin
					next_st.host_cnt = RST_COUNTER;
				end
				ADDR_CLR_ECC: begin
					next_st.disk_cnt = RST_COUNTER;
				end
				ADDR_DRQ_IRQ: begin
					// set wins over a same-cycle sector retire
					next_st.drq = 1'b1;
				end
				ADDR_RD_PREF: begin
					next_st.rd_mode = 1'b1;
				end
				ADDR_MULTI: begin
					next_st.multi = 1'b1;
				end
				ADDR_COUNT_IDLE: begin
					// a load opens a new command and wakes the logic
					next_st.left = (lcp_wdata == 8'h00) ? 9'h100 : {1'b0, lcp_wdata};
					next_st.ms = MS_RUN;
					next_st.term = 1'b0;
					next_st.corr = 1'b0;
					next_st.busy = 1'b1;
					next_st.sleep = 1'b0;
					next_st.idle = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// local reads; returned data only valid for the counters
		if (rd_sel) begin
			unique case (dec_addr)
				ADDR_HOST_CNT: begin
					next_st.rdata = st.host_cnt;
				end
				ADDR_DISK_CNT: begin
					next_st.rdata = st.disk_cnt;
				end
				ADDR_CLR_SLEEP: begin
					next_st.sleep = 1'b1;
					next_st.busy = 1'b0;
				end
				ADDR_CLR_ECC: begin
					next_st.ecc7 = 1'b1;
				end
				ADDR_DRQ_IRQ: begin
					next_st.irq = 1'b1;
				end
				ADDR_RD_PREF: begin
					next_st.prefetch = 1'b1;
				end
				ADDR_MULTI: begin
					next_st.multi = 1'b0;
				end
				ADDR_COUNT_IDLE: begin
					next_st.idle = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// run flag kept in its own flop so the output needs no decode
		next_st.active = (next_st.ms == MS_RUN);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// strobes are assumed single-cycle, so each fires once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.ms <= MS_IDLE;
			st.err <= DIAG_NONE;
			st.left <= RST_SECTORS;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign lcp_rdata = st.rdata;
	assign lcp_hit = st.hit;
	assign param_data = st.pdata;
	assign host_block_cnt = st.host_cnt;
	assign disk_block_cnt = st.disk_cnt;
	assign host_drq = st.drq;
	assign host_irq = st.irq;
	assign busy = st.busy;
	assign sleep_mode = st.sleep;
	assign idle_mode = st.idle;
	assign ecc7_mode = st.ecc7;
	assign read_mode = st.rd_mode;
	assign prefetch = st.prefetch;
	assign multi_mode = st.multi;
	assign cmd_active = st.active;
	assign cmd_terminated = st.term;
	assign corrected_seen = st.corr;
	assign sectors_left = st.left;
	assign error_code = st.err;

endmodule

/* design/dbs_pkg.sv */
// shared constants for the disk buffer support decode block
package dbs_pkg;

	// ---------------------------------------------------------------
	// local bus command addresses, six decoded bits
	// ---------------------------------------------------------------
	localparam logic [5:0] ADDR_HOST_CNT = 6'h20;
	localparam logic [5:0] ADDR_DISK_CNT = 6'h21;
	localparam logic [5:0] ADDR_CLR_SLEEP = 6'h22;
	localparam logic [5:0] ADDR_CLR_ECC = 6'h23;
	localparam logic [5:0] ADDR_DRQ_IRQ = 6'h24;
	localparam logic [5:0] ADDR_RD_PREF = 6'h25;
	localparam logic [5:0] ADDR_MULTI = 6'h26;
	localparam logic [5:0] ADDR_COUNT_IDLE = 6'h27;
	localparam int ADDR_DECODE_BITS = 6;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_COUNTER = 8'h00;
	localparam logic [8:0] RST_SECTORS = 9'h000;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ---------------------------------------------------------------
	// diagnostic result codes
	// ---------------------------------------------------------------
	localparam logic [7:0] DIAG_NONE = 8'h00;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] DIAG_CTRL_ERR = 8'h02;
	localparam logic [7:0] DIAG_BUF_ERR = 8'h03;
	localparam logic [7:0] DIAG_PATH_ERR = 8'h04;
	localparam logic [7:0] DIAG_PROC_ERR = 8'h05;

	// ---------------------------------------------------------------
	// parameter block layout
	// ---------------------------------------------------------------
	localparam int PB_WORDS = 49;
	localparam int PB_CFG_LAST = 9;
	localparam int PB_SERIAL = 10;
	localparam int PB_SERIAL_LAST = 19;
	localparam int PB_TYPE = 20;
	localparam int PB_BUFSIZE = 21;
	localparam int PB_ECCBYTES = 22;
	localparam int PB_FW = 23;
	localparam int PB_FW_LAST = 26;
	localparam int PB_MODEL = 27;
	localparam int PB_MODEL_LAST = 46;
	localparam int PB_PER_INT = 47;
	localparam int PB_DWORD = 48;
	localparam logic [15:0] CTYPE_DUAL_CACHE = 16'h0003;
	localparam logic [15:0] BUF_UNITS = 16'h0020;
	localparam logic [15:0] LONG_ECC_BYTES = 16'h0004;
	localparam logic [15:0] SECT_PER_INT = 16'h0001;
	localparam logic [15:0] DWORD_NO = 16'h0000;

	// multi-sector sequencing
	typedef enum logic [1:0] {
		MS_IDLE,
		MS_RUN,
		MS_STOP
	} dbs_ms_e;

endpackage

/* design/dbs_param_rom.sv */
// parameter block word table handed to the host
module dbs_param_rom
	import dbs_pkg::*;
#(
	parameter logic [159:0] CFG_WORDS = '0,
	parameter logic [159:0] SERIAL = '0,
	parameter logic [63:0] FW_REV = {8{8'h30}},
	parameter logic [319:0] MODEL = {40{8'h20}}
) (
	// word select and data
	input wire logic [5:0] word_index,
	output logic [15:0] word_data
);

	int idx;

	// fixed table lookup, out-of-range words read zero
	always_comb begin
		idx = int'(word_index);
		word_data = 16'h0000;
		if (idx <= PB_CFG_LAST) begin
			word_data = CFG_WORDS[159 - 16*idx -: 16];
		end else if (idx <= PB_SERIAL_LAST) begin
			word_data = SERIAL[159 - 16*(idx - PB_SERIAL) -: 16];
		end else if (idx == PB_TYPE) begin
			word_data = CTYPE_DUAL_CACHE;
		end else if (idx == PB_BUFSIZE) begin
			word_data = BUF_UNITS;
		end else if (idx == PB_ECCBYTES) begin
			word_data = LONG_ECC_BYTES;
		end else if (idx <= PB_FW_LAST) begin
			word_data = FW_REV[63 - 16*(idx - PB_FW) -: 16];
		end else if (idx <= PB_MODEL_LAST) begin
			word_data = MODEL[319 - 16*(idx - PB_MODEL) -: 16];
		end else if (idx == PB_PER_INT) begin
			word_data = SECT_PER_INT;
		end else if (idx == PB_DWORD) begin
			word_data = DWORD_NO;
		end
	end

endmodule

/* bench/dbs_decode_props.sv */
// checker for the support decode port behaviour
module dbs_decode_props
	import dbs_pkg::*;
(
	// clock and reset
	input logic clk,
	input logic reset_n,
	// local bus
	input logic [7:0] lcp_addr,
	input logic [7:0] lcp_wdata,
	input logic lcp_wr,
	input logic lcp_rd,
	input logic lcp_hit,
	// event strobes
	input logic host_byte_xfer,
	input logic sector_done,
	input logic ctrl_fault,
	input logic uncorr_err,
	input logic corr_err,
	// watched state
	input logic [7:0] host_block_cnt,
	input logic multi_mode,
	input logic cmd_active,
	input logic cmd_terminated,
	input logic corrected_seen,
	input logic [8:0] sectors_left
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------
	// decode helpers
	// ---------------------------------------------
	logic sel, wt;
	logic [5:0] a6;
	// top two address bits never take part
	assign a6 = lcp_addr[5:0];
	assign sel = (lcp_wr || lcp_rd) && a6[5:3] == 3'h4;
	assign wt = lcp_wr && sel;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	cmd_hit_a: assert property (sel |=> lcp_hit)
		else $error("support access gave no hit");
	reserved_quiet_a: assert property (!sel |=> !lcp_hit)
		else $error("hit outside the command range");
	host_clear_a: assert property (
		wt && a6 == ADDR_CLR_SLEEP |=> host_block_cnt == 8'h00)
		else $error("host counter not cleared");
	multi_flag_a: assert property (
		sel && a6 == ADDR_MULTI |=> multi_mode == $past(lcp_wr))
		else $error("multi mode wrong after command");
	// zero count means the full 256 sectors
	count_load_a: assert property (
		wt && a6 == ADDR_COUNT_IDLE |=> cmd_active &&
		sectors_left == {$past(lcp_wdata) == 8'h00, $past(lcp_wdata)})
		else $error("sector count load wrong");
	host_adv_a: assert property (
		host_byte_xfer && !lcp_wr |=> host_block_cnt == $past(host_block_cnt) + 8'h01)
		else $error("host counter did not advance");
	fault_end_a: assert property (
		cmd_active && (ctrl_fault || uncorr_err) && !lcp_wr |=> !cmd_active && cmd_terminated)
		else $error("fault did not end command");
	corr_keep_a: assert property (
		cmd_active && corr_err && !lcp_wr && !(sector_done || ctrl_fault || uncorr_err)
		|=> cmd_active && corrected_seen && $stable(sectors_left))
		else $error("corrected error disturbed command");
	cover property (wt && a6 == ADDR_COUNT_IDLE);
	cover property (cmd_active && uncorr_err);
	cover property (host_byte_xfer);
endmodule

/* bench/dbs_lcp_model.sv */
// local control processor model driving the support command bus
module dbs_lcp_model (
	// clock
	input logic clk,
	// local bus
	output logic [7:0] lcp_addr = 8'h00,
	output logic [7:0] lcp_wdata = 8'h00,
	output logic lcp_wr = 1'b0,
	output logic lcp_rd = 1'b0,
	input logic [7:0] lcp_rdata,
	input logic lcp_hit
);
	timeunit 1ns;
	timeprecision 1ns;
	// only this processor reaches the support commands
	// one strobe cycle from a falling edge; answer taken a cycle later
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic h);
		@(negedge clk);
		lcp_addr = a;
		lcp_wdata = d;
		lcp_wr = w;
		lcp_rd = !w;
		@(negedge clk);
		lcp_wr = 1'b0;
		lcp_rd = 1'b0;
		// released bus shows no stale value
		lcp_addr = ~a;
		lcp_wdata = ~d;
		q = lcp_rdata;
		h = lcp_hit;
	endtask
endmodule

/* bench/tb_disk_buffer_support_decode.sv */
// self-checking bench for the disk buffer support decode block
module tb_disk_buffer_support_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n;
	logic [7:0] lcp_addr, lcp_wdata, lcp_rdata, host_block_cnt, disk_block_cnt, error_code, q;
	logic lcp_wr, lcp_rd, lcp_hit, host_drq, host_irq, busy, sleep_mode, idle_mode, h;
	logic ecc7_mode, read_mode, prefetch, multi_mode, cmd_active, cmd_terminated;
	logic corrected_seen;
	logic [8:0] sectors_left;
	logic [15:0] param_data;
	logic [5:0] param_index;
	// diag_done, host, disk, sector_done, ctrl_fault, uncorr_err, corr_err
	logic [6:0] ev;
	logic [3:0] dg;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [7:0] rsv [7] = '{8'h00, 8'h07, 8'h10, 8'h17, 8'h30, 8'h3F, 8'h28};
	logic [3:0] dok [6] = '{4'hF, 4'h7, 4'hB, 4'hD, 4'hE, 4'h0};
	logic [7:0] dres [6] = '{8'h01, 8'h05, 8'h03, 8'h04, 8'h02, 8'h05};
	// distinct table contents so a wrong word index shows up
	logic [5:0] pidx [14] = '{6'h14, 6'h15, 6'h16, 6'h2F, 6'h30, 6'h0A, 6'h13, 6'h17,
		6'h1A, 6'h1B, 6'h2E, 6'h00, 6'h09, 6'h31};
	logic [15:0] pval [14] = '{16'h0003, 16'h0020, 16'h0004, 16'h0001, 16'h0000,
		16'h5330, 16'h5339, 16'h3132, 16'h3738, 16'h4D20, 16'h205A, 16'hC000, 16'hC009,
		16'h0000};

	always #25 clk = ~clk;

	dbs_decode #(
		.CFG_WORDS(160'hC000_C001_C002_C003_C004_C005_C006_C007_C008_C009),
		.SERIAL(160'h5330_5331_5332_5333_5334_5335_5336_5337_5338_5339),
		.FW_REV(64'h3132_3334_3536_3738),
		.MODEL({8'h4D, {38{8'h20}}, 8'h5A})
	) dut_u (.clk, .reset_n, .lcp_addr, .lcp_wdata, .lcp_wr, .lcp_rd, .lcp_rdata,
		.lcp_hit, .host_byte_xfer(ev[5]), .disk_byte_xfer(ev[4]), .sector_done(ev[3]),
		.ctrl_fault(ev[2]), .uncorr_err(ev[1]), .corr_err(ev[0]), .diag_done(ev[6]),
		.diag_proc_ok(dg[3]), .diag_buf_ok(dg[2]), .diag_path_ok(dg[1]),
		.diag_ctrl_ok(dg[0]), .param_index, .param_data, .host_block_cnt, .disk_block_cnt,
		.host_drq, .host_irq, .busy, .sleep_mode, .idle_mode, .ecc7_mode, .read_mode,
		.prefetch, .multi_mode, .cmd_active, .cmd_terminated, .corrected_seen,
		.sectors_left, .error_code);
	dbs_lcp_model lcp_u (.clk, .lcp_addr, .lcp_wdata, .lcp_wr, .lcp_rd, .lcp_rdata, .lcp_hit);

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		lcp_u.acc(1'b1, a, d, q, h);
	endtask
	task automatic rd(input logic [7:0] a);
		lcp_u.acc(1'b0, a, 8'h00, q, h);
	endtask
	// one-cycle event pulse launched at a falling edge
	task automatic pulse(input logic [6:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 7'h00;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// cut a hang short; the run needs about 120 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			results();
		end
	end

	// ---------------------------------------------
	// test sequence
	// ---------------------------------------------
	initial begin
		reset_n = 1'b0;
		ev = 7'h00;
		dg = 4'hF;
		param_index = 6'h00;
		repeat (4) @(negedge clk);
		chk("rst hcnt", host_block_cnt, 8'h00);
		chk("rst err", error_code, 8'h00);
		reset_n = 1'b1;
		$display("test reset done");
		wr(8'h20, 8'h5A);
		rd(8'h20);
		chk("hcnt rd", q, 8'h5A);
		wr(8'hE1, 8'hA5);
		rd(8'h61);
		chk("dcnt alias", q, 8'hA5);
		chk("dcnt hit", h, 1'b1);
		pulse(7'h20);
		pulse(7'h20);
		chk("hcnt adv", host_block_cnt, 8'h5C);
		pulse(7'h10);
		chk("dcnt adv", disk_block_cnt, 8'hA6);
		wr(8'h22, 8'h00);
		chk("hcnt clr", host_block_cnt, 8'h00);
		chk("dcnt kept", disk_block_cnt, 8'hA6);
		wr(8'h23, 8'h00);
		chk("dcnt clr", disk_block_cnt, 8'h00);
		$display("test counters done");
		wr(8'h27, 8'h02);
		chk("busy", busy, 1'b1);
		rd(8'h22);
		chk("sleep", {sleep_mode, busy}, 2'b10);
		rd(8'h23);
		chk("ecc7", ecc7_mode, 1'b1);
		wr(8'h24, 8'h00);
		chk("drq", host_drq, 1'b1);
		rd(8'h24);
		chk("irq", host_irq, 1'b1);
		@(negedge clk);
		chk("irq end", host_irq, 1'b0);
		wr(8'h25, 8'h00);
		chk("rdmode", read_mode, 1'b1);
		rd(8'h25);
		chk("prefetch", prefetch, 1'b1);
		wr(8'h26, 8'h00);
		chk("multi set", multi_mode, 1'b1);
		rd(8'h26);
		chk("multi clr", multi_mode, 1'b0);
		rd(8'h27);
		chk("idle", idle_mode, 1'b1);
		$display("test modes done");
		foreach (rsv[i]) begin
			wr(rsv[i], 8'hFF);
			chk("rsv hit", h, 1'b0);
		end
		chk("rsv cnt", host_block_cnt, 8'h00);
		$display("test reserved done");
		wr(8'h26, 8'h00);
		wr(8'h27, 8'h03);
		chk("load", sectors_left, 9'h003);
		pulse(7'h01);
		chk("corr", {cmd_active, corrected_seen, sectors_left}, 11'h603);
		pulse(7'h08);
		chk("sector", sectors_left, 9'h002);
		chk("drq clr", host_drq, 1'b0);
		pulse(7'h02);
		chk("uncorr", {cmd_active, cmd_terminated}, 2'b01);
		wr(8'h27, 8'h00);
		chk("full", {cmd_terminated, sectors_left}, 10'h100);
		pulse(7'h0C);
		chk("fault", {cmd_active, cmd_terminated}, 2'b01);
		rd(8'h26);
		wr(8'h27, 8'h05);
		pulse(7'h08);
		chk("single", {cmd_active, sectors_left}, 10'h004);
		$display("test multi done");
		foreach (dok[i]) begin
			dg = dok[i];
			pulse(7'h40);
			chk("diag", error_code, dres[i]);
		end
		$display("test diag done");
		foreach (pidx[i]) begin
			@(negedge clk);
			param_index = pidx[i];
			@(negedge clk);
			chk("param", param_data, pval[i]);
		end
		$display("test params done");
		results();
	end
endmodule

bind dbs_decode dbs_decode_props chk_u (.*);
